// ### hdl/pirq_ctrl.sv
// How it works
// - Enable-register-1/2 sources need the peripheral gate bit to interrupt.
// - Enable register 2: bit7 capcmp2, bit6 nvm, bit5 timer1 gate, reset 0.
// - Enable register 1: bit1 serial port, bit0 ADC enable.
// - Flags set by events regardless of any enable.
// - Request 0 bit5 sets on timer0 overflow, cleared by software.
// - Request 0 bit4 is the OR of all port pin-change flags.
// - Request 0 bit0 sets on a valid external pin edge.
// - Request 1: bits 7,6,5,2,1,0 RW and hardware set; 4,3 read-only.
// - Capcmp flags set on capture, match or PWM trailing edge.
// - Timer2, timer1, serial and ADC flags sticky until cleared.
// - Receive flag follows non-empty receive buffer; read-only.
// - Transmit flag shows empty transmit buffer; read-only.
// - Request 1 bit2 sets on bus collision, cleared by software.
// - External pin chosen by a pin-select register.
// - No interrupt while global allow is clear; pending ones wait.
// - Enable-register-0 sources need only global allow.
// - Request 2 bit6 nvm done, bit5 timer1 gate inactive, software cleared.
`timescale 1ns/100ps
`default_nettype none
module pirq_ctrl #(
  parameter int PIN_N = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             timer0_ovf,
  input  wire logic [23:0]      port_pin_change_flags,
  input  wire logic [PIN_N-1:0] ext_pins,
  input  wire logic             capcmp1_event,
  input  wire logic             capcmp2_event,
  input  wire logic             timer2_event,
  input  wire logic             timer1_event,
  input  wire logic             rx_buffer_nonempty,
  input  wire logic             tx_buffer_empty,
  input  wire logic             bus_collision,
  input  wire logic             serial_event,
  input  wire logic             adc_event,
  input  wire logic             nvm_event,
  input  wire logic             timer1_gate_inactive,
  output logic                  core_irq
);
  import pirq_pkg::*;

  logic [7:0]  req0_q, req1_q, req2_q, en0_q, en1_q, en2_q, ctrl_q;
  logic [2:0]  ext_irq_pin_select_q;
  logic [PIN_N-1:0] pin_s1_q, pin_s2_q;
  logic        pin_prev_q;
  logic        pin_now;
  logic        ext_edge;
  logic        wr_acc, rd_acc;
  logic [11:0] addr;
  logic [7:0]  wbyte, rbyte;
  logic [7:0]  req1_view;
  logic        irq_d;
  logic        hit0, hit12;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait state, unmapped reads zero and error
  // Word addressed: byte address is four times the register index
  assign addr   = paddr[13:2];
  assign wbyte  = pwdata[7:0];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_comb begin
    // Read-only bits show live buffer state
    req1_view = req1_q;
    req1_view[PIRQ_B_RX] = rx_buffer_nonempty;
    req1_view[PIRQ_B_TX] = tx_buffer_empty;
    unique case (addr)
      PIRQ_REQ0_ADDR: rbyte = req0_q;
      PIRQ_REQ1_ADDR: rbyte = req1_view;
      PIRQ_REQ2_ADDR: rbyte = req2_q;
      PIRQ_EN0_ADDR:  rbyte = en0_q;
      PIRQ_EN1_ADDR:  rbyte = en1_q;
      PIRQ_EN2_ADDR:  rbyte = en2_q;
      PIRQ_CTRL_ADDR: rbyte = ctrl_q;
      PIRQ_PSEL_ADDR: rbyte = {5'h00, ext_irq_pin_select_q};
      default:        rbyte = 8'h00;
    endcase
  end

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == PIRQ_REQ0_ADDR) || (a == PIRQ_REQ1_ADDR) || (a == PIRQ_REQ2_ADDR)
          || (a == PIRQ_EN0_ADDR) || (a == PIRQ_EN1_ADDR) || (a == PIRQ_EN2_ADDR)
          || (a == PIRQ_CTRL_ADDR) || (a == PIRQ_PSEL_ADDR);
  endfunction : mapped

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready is registered so an access ends one edge after penable rises
      pready  <= psel && !penable;
      pslverr <= psel && !penable
              && (!mapped(addr) || paddr[31:14] != 18'h0_0000 || paddr[1:0] != 2'b00);
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rbyte} : prdata;
    end
  end

  logic do_wr;
  assign do_wr = wr_acc && pready && !pslverr;

  ////////////////////////////////////////////////////////////////////////
  // Enable, control and pin-select registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en0_q  <= PIRQ_RST_VAL;
      en1_q  <= PIRQ_RST_VAL;
      en2_q  <= PIRQ_RST_VAL;
      ctrl_q <= PIRQ_RST_VAL;
      ext_irq_pin_select_q <= PIRQ_SEL_RST;
    end else if (do_wr) begin
      if (addr == PIRQ_EN0_ADDR) en0_q <= wbyte & PIRQ_REQ0_MASK;
      // Full byte of enable register 1 writable
      if (addr == PIRQ_EN1_ADDR) en1_q <= wbyte;
      // Only the top three bits exist
      if (addr == PIRQ_EN2_ADDR) en2_q <= wbyte & PIRQ_REQ2_MASK;
      if (addr == PIRQ_CTRL_ADDR) ctrl_q <= wbyte & PIRQ_CTRL_MASK;
      if (addr == PIRQ_PSEL_ADDR) ext_irq_pin_select_q <= wbyte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External pin: synchronise all, then select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= ext_pins;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_now;
    end
  end

  // Source pin picked by the select register
  assign pin_now  = pin_s2_q[ext_irq_pin_select_q[$clog2(PIN_N)-1:0]];
  // Selector change can fake an edge; software should clear the flag after
  assign ext_edge = ctrl_q[PIRQ_B_EDGE] ? (pin_now && !pin_prev_q)
                                        : (!pin_now && pin_prev_q);

  ////////////////////////////////////////////////////////////////////////
  // Request flags: hardware set wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req0_q <= PIRQ_RST_VAL;
    end else begin
      if (do_wr && addr == PIRQ_REQ0_ADDR) begin
        req0_q[PIRQ_B_TMR0] <= wbyte[PIRQ_B_TMR0];
        req0_q[PIRQ_B_EXT]  <= wbyte[PIRQ_B_EXT];
      end
      // Timer0 overflow sets regardless of enables
      if (timer0_ovf) req0_q[PIRQ_B_TMR0] <= 1'b1;
      // Valid edge on the chosen pin
      if (ext_edge) req0_q[PIRQ_B_EXT] <= 1'b1;
      // Summary follows lower-level flags, not writable
      req0_q[PIRQ_B_PCHG] <= |port_pin_change_flags;
    end
  end

  logic [7:0] req1_set;
  // Event sources of request register 1
  assign req1_set = {capcmp1_event, timer2_event, timer1_event, 2'b00,
                     bus_collision, serial_event, adc_event};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req1_q <= PIRQ_RST_VAL;
    end else begin
      // Writable bits only; set has priority
      if (do_wr && addr == PIRQ_REQ1_ADDR)
        req1_q <= (wbyte & PIRQ_REQ1_SW) | (req1_set & PIRQ_REQ1_SW);
      else
        req1_q <= req1_q | (req1_set & PIRQ_REQ1_SW);
    end
  end

  logic [7:0] req2_set;
  // Capcmp2, nvm done, timer1 gate inactive
  assign req2_set = {capcmp2_event, nvm_event, timer1_gate_inactive, 5'h00};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req2_q <= PIRQ_RST_VAL;
    end else if (do_wr && addr == PIRQ_REQ2_ADDR) begin
      req2_q <= (wbyte & PIRQ_REQ2_MASK) | req2_set;
    end else begin
      req2_q <= req2_q | req2_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core request
  // Live buffer states enter via req1_view
  assign hit0  = |(req0_q & en0_q);
  assign hit12 = |(req1_view & en1_q) || |(req2_q & en2_q);
  assign irq_d = ctrl_q[PIRQ_B_GLOBAL] && (hit0 || (ctrl_q[PIRQ_B_PGATE] && hit12));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) core_irq <= 1'b0;
    else        core_irq <= irq_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic wr_req0, wr_req1, wr_req2;
  assign wr_req0 = do_wr && (addr == PIRQ_REQ0_ADDR);
  assign wr_req1 = do_wr && (addr == PIRQ_REQ1_ADDR);
  assign wr_req2 = do_wr && (addr == PIRQ_REQ2_ADDR);

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  // A clear right after the event is legal, so stickiness is owed only when none follows
  sequence s_ccp_kept;
    capcmp1_event ##1 !wr_req1;
  endsequence
  // Request held back by global allow, then allowed
  sequence s_pending_held;
    (!ctrl_q[PIRQ_B_GLOBAL] && hit0) ##1 (ctrl_q[PIRQ_B_GLOBAL] && hit0);
  endsequence

  a_global_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_q[PIRQ_B_GLOBAL] |=> !core_irq)
    else $error("irq raised with global allow clear");
  a_gate_needed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_q[PIRQ_B_PGATE] && !hit0) |=> !core_irq)
    else $error("peripheral irq passed without gate");
  a_reg0_direct: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_q[PIRQ_B_GLOBAL] && hit0) |=> core_irq)
    else $error("reg0 source did not interrupt");
  a_timer0_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer0_ovf |=> req0_q[PIRQ_B_TMR0])
    else $error("timer0 flag not set");
  a_pchg_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> req0_q[PIRQ_B_PCHG] == |$past(port_pin_change_flags))
    else $error("pin change summary wrong");
  a_ext_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_edge |=> req0_q[PIRQ_B_EXT])
    else $error("external flag not set");
  a_ccp_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ccp_kept |-> req1_q[PIRQ_B_CCP] [*2])
    else $error("capcmp1 flag not sticky");
  a_bcol_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_collision |=> req1_q[PIRQ_B_BCOL])
    else $error("collision flag not set");
  a_adc_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    adc_event |=> req1_q[PIRQ_B_ADC])
    else $error("adc flag not set");
  a_ro_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req1_q[PIRQ_B_RX:PIRQ_B_TX] == 2'b00)
    else $error("read-only bits stored");
  a_nvm_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    nvm_event |=> req2_q[PIRQ_B_NVM])
    else $error("nvm flag not set");
  a_en2_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en2_q[4:0] == 5'h00)
    else $error("enable 2 low bits set");
  a_apb_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_apb_setup |=> pready)
    else $error("no ready after setup");
  a_err_with_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error without ready");
  a_rd_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && addr == PIRQ_REQ1_ADDR) |=>
    (prdata[PIRQ_B_RX] == $past(rx_buffer_nonempty) && prdata[PIRQ_B_TX] == $past(tx_buffer_empty)))
    else $error("buffer state not read live");
  a_req1_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_req1 |=> req1_q == (($past(wbyte) | $past(req1_set)) & PIRQ_REQ1_SW))
    else $error("request 1 write wrong");
  a_req1_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!wr_req1 && req1_set == 8'h00) |=> req1_q == $past(req1_q))
    else $error("request 1 flags not held");
  a_timer2_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer2_event |=> req1_q[PIRQ_B_TMR2])
    else $error("timer2 flag not set");
  a_timer1_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer1_event |=> req1_q[PIRQ_B_TMR1])
    else $error("timer1 flag not set");
  a_serial_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_event |=> req1_q[PIRQ_B_SSP])
    else $error("serial flag not set");
  a_ccp2_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    capcmp2_event |=> req2_q[PIRQ_B_CCP])
    else $error("capcmp2 flag not set");
  a_t1gate_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer1_gate_inactive |=> req2_q[PIRQ_B_T1GATE])
    else $error("timer1 gate flag not set");
  a_req2_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_req2 |=> req2_q == (($past(wbyte) & PIRQ_REQ2_MASK) | $past(req2_set)))
    else $error("request 2 write wrong");
  a_req2_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!wr_req2 && req2_set == 8'h00) |=> req2_q == $past(req2_q))
    else $error("request 2 flags not held");
  a_tmr0_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req0_q[PIRQ_B_TMR0] && !wr_req0) |=> req0_q[PIRQ_B_TMR0])
    else $error("timer0 flag lost");
  a_ext_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req0_q[PIRQ_B_EXT] && !wr_req0) |=> req0_q[PIRQ_B_EXT])
    else $error("external flag lost");
  a_ext_rising: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_q[PIRQ_B_EDGE] && $rose(pin_now)) |=> req0_q[PIRQ_B_EXT])
    else $error("rising edge missed");
  a_ext_falling: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_q[PIRQ_B_EDGE] && $fell(pin_now)) |=> req0_q[PIRQ_B_EXT])
    else $error("falling edge missed");
  a_en0_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_wr && addr == PIRQ_EN0_ADDR) |=> en0_q == ($past(wbyte) & PIRQ_REQ0_MASK))
    else $error("enable 0 write wrong");
  a_en1_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_wr && addr == PIRQ_EN1_ADDR) |=> en1_q == $past(wbyte))
    else $error("enable 1 write wrong");
  a_en2_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_wr && addr == PIRQ_EN2_ADDR) |=> en2_q == ($past(wbyte) & PIRQ_REQ2_MASK))
    else $error("enable 2 write wrong");
  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_wr && addr == PIRQ_CTRL_ADDR) |=> ctrl_q == ($past(wbyte) & PIRQ_CTRL_MASK))
    else $error("control write wrong");
  a_psel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (do_wr && addr == PIRQ_PSEL_ADDR) |=> ext_irq_pin_select_q == $past(wbyte[2:0]))
    else $error("pin select write wrong");
  a_periph_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_q[PIRQ_B_GLOBAL] && ctrl_q[PIRQ_B_PGATE] && hit12) |=> core_irq)
    else $error("peripheral irq not raised");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hit0 && !hit12) |=> !core_irq)
    else $error("irq without an enabled flag");
  a_pending_served: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pending_held |=> core_irq)
    else $error("pending request not served");
  a_reset_vals: assert property (@(posedge ref_clk)
    !rst_n |=> (req1_q == PIRQ_RST_VAL && en2_q == PIRQ_RST_VAL && !core_irq))
    else $error("state not cleared by reset");
endmodule : pirq_ctrl
`default_nettype wire

// ### hdl/pirq_pkg.sv
package pirq_pkg;
  // Register word indices; the APB byte address is four times the index
  localparam logic [11:0] PIRQ_REQ0_ADDR  = 12'h70C;
  localparam logic [11:0] PIRQ_REQ1_ADDR  = 12'h70D;
  localparam logic [11:0] PIRQ_REQ2_ADDR  = 12'h70E;
  localparam logic [11:0] PIRQ_EN0_ADDR   = 12'h716;
  localparam logic [11:0] PIRQ_EN1_ADDR   = 12'h717;
  localparam logic [11:0] PIRQ_EN2_ADDR   = 12'h718;
  localparam logic [11:0] PIRQ_CTRL_ADDR  = 12'h70B;
  localparam logic [11:0] PIRQ_PSEL_ADDR  = 12'h719;
  // Field positions
  localparam int PIRQ_B_TMR0    = 5;
  localparam int PIRQ_B_PCHG    = 4;
  localparam int PIRQ_B_EXT     = 0;
  localparam int PIRQ_B_CCP     = 7;
  localparam int PIRQ_B_TMR2    = 6;
  localparam int PIRQ_B_TMR1    = 5;
  localparam int PIRQ_B_RX      = 4;
  localparam int PIRQ_B_TX      = 3;
  localparam int PIRQ_B_BCOL    = 2;
  localparam int PIRQ_B_SSP     = 1;
  localparam int PIRQ_B_ADC     = 0;
  localparam int PIRQ_B_NVM     = 6;
  localparam int PIRQ_B_T1GATE  = 5;
  localparam int PIRQ_B_GLOBAL  = 7;
  localparam int PIRQ_B_PGATE   = 6;
  localparam int PIRQ_B_EDGE    = 0;
  // Implemented bits and reset values
  localparam logic [7:0] PIRQ_REQ0_MASK = 8'h31;
  localparam logic [7:0] PIRQ_REQ1_SW   = 8'hE7;
  localparam logic [7:0] PIRQ_REQ2_MASK = 8'hE0;
  localparam logic [7:0] PIRQ_CTRL_MASK = 8'hC1;
  localparam logic [7:0] PIRQ_RST_VAL   = 8'h00;
  localparam logic [2:0] PIRQ_SEL_RST   = 3'h0;
endpackage : pirq_pkg

// ### test/peripheral_irq_flag_enable_test.sv
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flag_enable_test;
  import pirq_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] m;} pirq_row_s;
  localparam logic [11:0] SEL = PIRQ_PSEL_ADDR;
  localparam logic [11:0] R1A = PIRQ_REQ1_ADDR;
  localparam logic [11:0] R2A = PIRQ_REQ2_ADDR;
  logic        ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, v;
  logic        pready, pslverr, core_irq, err, rx_ne = 1'h0, tx_em = 1'h0;
  logic [23:0] pcf = 24'h0;
  logic [7:0]  pins = 8'h00;
  logic [9:0]  fire = 10'h000, pulse;
  int          bad_count = 0, num_checks = 0;
  pirq_row_s   rows [10] = '{'{PIRQ_REQ0_ADDR, 8'h20}, '{R1A, 8'h80}, '{R1A, 8'h40},
    '{R1A, 8'h20}, '{R1A, 8'h04}, '{R1A, 8'h02}, '{R1A, 8'h01}, '{R2A, 8'h80},
    '{R2A, 8'h40}, '{R2A, 8'h20}};
  logic [11:0] rst_regs [8] = '{PIRQ_REQ0_ADDR, R1A, R2A, PIRQ_EN0_ADDR, PIRQ_EN1_ADDR,
    PIRQ_EN2_ADDR, PIRQ_CTRL_ADDR, SEL};

  pirq_src_model i_pirq_src_model (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .pulse(pulse));
  pirq_ctrl #(.PIN_N(8)) i_pirq_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_ovf(pulse[0]), .port_pin_change_flags(pcf),
    .ext_pins(pins), .capcmp1_event(pulse[1]), .capcmp2_event(pulse[7]),
    .timer2_event(pulse[2]), .timer1_event(pulse[3]), .rx_buffer_nonempty(rx_ne),
    .tx_buffer_empty(tx_em), .bus_collision(pulse[4]), .serial_event(pulse[5]),
    .adc_event(pulse[6]), .nvm_event(pulse[8]), .timer1_gate_inactive(pulse[9]),
    .core_irq(core_irq));

  initial forever #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {18'h0, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      bad_count++;
      print_verdict();
    end
    v = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic ev(input int i);
    @(posedge ref_clk);
    fire <= 10'h001 << i;
    @(posedge ref_clk);
    fire <= 10'h000;
    repeat (2) @(posedge ref_clk);
  endtask : ev

  // Hang guard, counted as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      ev(i);
      apb(1'h0, rows[i].a, 8'h00);
      chk(v, {24'h0, rows[i].m});
      apb(1'h1, rows[i].a, 8'h00);
      apb(1'h0, rows[i].a, 8'h00);
      chk(v, 32'h0);
    end
    rx_ne <= 1'h1;
    tx_em <= 1'h1;
    apb(1'h1, R1A, 8'h00);
    apb(1'h0, R1A, 8'h00);
    chk(v, 32'h18);
    rx_ne <= 1'h0;
    apb(1'h1, R1A, 8'hFF);
    apb(1'h0, R1A, 8'h00);
    chk(v, 32'hEF);
    tx_em <= 1'h0;
    apb(1'h1, R1A, 8'h00);
    pcf <= 24'h020000;
    apb(1'h1, PIRQ_REQ0_ADDR, 8'h00);
    apb(1'h0, PIRQ_REQ0_ADDR, 8'h00);
    chk(v, 32'h10);
    pcf <= 24'h0;
    apb(1'h0, PIRQ_REQ0_ADDR, 8'h00);
    chk(v, 32'h0);
    apb(1'h1, PIRQ_CTRL_ADDR, 8'h01);
    apb(1'h1, SEL, 8'h03);
    pins <= 8'h01;
    repeat (4) @(posedge ref_clk);
    apb(1'h0, PIRQ_REQ0_ADDR, 8'h00);
    chk(v, 32'h0);
    pins <= 8'h09;
    repeat (4) @(posedge ref_clk);
    apb(1'h0, PIRQ_REQ0_ADDR, 8'h00);
    chk(v, 32'h01);
    apb(1'h1, PIRQ_REQ0_ADDR, 8'h00);
    // Falling edge once edge select is clear
    apb(1'h1, PIRQ_CTRL_ADDR, 8'h00);
    pins <= 8'h01;
    repeat (4) @(posedge ref_clk);
    apb(1'h0, PIRQ_REQ0_ADDR, 8'h00);
    chk(v, 32'h01);
    apb(1'h1, PIRQ_REQ0_ADDR, 8'h00);
    // Flag is clear before its enable is set
    apb(1'h1, PIRQ_EN1_ADDR, 8'h01);
    ev(6);
    chk(core_irq, 32'h0);
    apb(1'h1, PIRQ_CTRL_ADDR, 8'h80);
    repeat (2) @(posedge ref_clk);
    chk(core_irq, 32'h0);
    apb(1'h1, PIRQ_CTRL_ADDR, 8'hC0);
    repeat (2) @(posedge ref_clk);
    chk(core_irq, 32'h1);
    apb(1'h1, R1A, 8'h00);
    apb(1'h1, PIRQ_CTRL_ADDR, 8'h80);
    apb(1'h1, PIRQ_EN0_ADDR, 8'h20);
    repeat (2) @(posedge ref_clk);
    chk(core_irq, 32'h0);
    ev(0);
    repeat (2) @(posedge ref_clk);
    chk(core_irq, 32'h1);
    apb(1'h1, PIRQ_REQ0_ADDR, 8'h00);
    apb(1'h1, PIRQ_EN2_ADDR, 8'hFF);
    apb(1'h0, PIRQ_EN2_ADDR, 8'h00);
    chk(v, 32'hE0);
    ev(8);
    apb(1'h1, PIRQ_CTRL_ADDR, 8'hC0);
    repeat (2) @(posedge ref_clk);
    chk(core_irq, 32'h1);
    apb(1'h1, 12'h710, 8'hFF);
    chk(err, 32'h1);
    apb(1'h0, 12'h710, 8'h00);
    chk(v, 32'h0);
    // Reset in mid-run clears all state
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    chk(core_irq, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, rst_regs[i], 8'h00);
      chk(v, 32'h0);
    end
    print_verdict();
  end
endmodule : peripheral_irq_flag_enable_test
`default_nettype wire

// ### test/pirq_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module pirq_src_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] fire,
  output logic      [9:0] pulse
);
  // Sources emit one-clock event pulses, never a level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pulse <= 10'h000;
    else pulse <= fire;
  end
endmodule : pirq_src_model
`default_nettype wire
